// File: core/ppg_defs.svh
// Purpose: constants for the processor power-good sequencer
// Assumes: bus clock of 250 MHz (4 ns period)
// Notes: times in their own units, cycle counts derived from them except PPG_PG_LOW_MIN_CYC, given in cycles
`ifndef PPG_DEFS_SVH
`define PPG_DEFS_SVH

// clock in cycles per microsecond keeps every product inside 32 bits
`define PPG_CLK_MHZ 250
`define PPG_IGNORE_US 500
`define PPG_IGNORE_CYC (`PPG_IGNORE_US * `PPG_CLK_MHZ)
`define PPG_OK_TIMEOUT_US 13000
`define PPG_OK_TIMEOUT_CYC (`PPG_OK_TIMEOUT_US * `PPG_CLK_MHZ)
`define PPG_PG_LOW_MIN_CYC 10
`define PPG_RST_US 1000
`define PPG_RST_CYC (`PPG_RST_US * `PPG_CLK_MHZ)
`define PPG_PG_TO_RST_US 1000
`define PPG_PG_TO_RST_CYC (`PPG_PG_TO_RST_US * `PPG_CLK_MHZ)
`define PPG_CNT_W 24

`endif

// File: core/ppg_pkg.sv
// Purpose: types for the processor power-good sequencer
// Assumes: nothing
// Notes: states of the sequencer
package ppg_pkg;
    typedef enum logic [2:0] {
        PPG_OFF,
        PPG_SETTLE,
        PPG_WAIT_OK,
        PPG_PG_LOW,
        PPG_RST_HOLD,
        PPG_RUN,
        PPG_FAULT
    } ppg_state_t;
endpackage

// File: core/ppg_sync_if.sv
// Purpose: carries synchronised inputs into the sequencer core
// Assumes: one clock domain
// Notes: level signals only
`timescale 1ns/1ps
`default_nettype none
interface ppg_sync_if #(parameter int N_REG = 2);
    logic [N_REG-1:0] regulator_module_good;
    logic cartridge_regulator_ok;
    logic core_supply_in_range;
    modport sync_mp (output regulator_module_good, cartridge_regulator_ok,
        core_supply_in_range);
    modport core_mp (input regulator_module_good, cartridge_regulator_ok,
        core_supply_in_range);
endinterface
`default_nettype wire

// File: core/ppg_sync.sv
// Purpose: two-stage synchroniser for all power status inputs
// Assumes: inputs are slow levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module ppg_sync #(
    parameter int N_REG = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // raw status
    input wire logic [N_REG-1:0] regulator_module_good_i,
    input wire logic cartridge_regulator_ok_i,
    input wire logic core_supply_in_range_i,
    // synchronised levels
    ppg_sync_if.sync_mp sy
);
    typedef struct packed {
        logic [N_REG+1:0] s1;
        logic [N_REG+1:0] s2;
    } ppg_sync_st_t;

    ppg_sync_st_t st_r;
    ppg_sync_st_t st_nxt;

    // shift raw levels through two stages
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = {regulator_module_good_i, cartridge_regulator_ok_i,
            core_supply_in_range_i};
        st_nxt.s2 = st_r.s1;
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // present second-stage outputs
    assign sy.regulator_module_good = st_r.s2[N_REG+1:2];
    assign sy.cartridge_regulator_ok = st_r.s2[1];
    assign sy.core_supply_in_range = st_r.s2[0];
endmodule
`default_nettype wire

// File: core/ppg_seq.sv
// Purpose: combine supply status into processor power-ok and time reset
// Assumes: inputs synchronous or slow; one 250 MHz bus clock
// Notes: a core supply or module good drop restarts the whole sequence; a cartridge ok drop does so from the low phase on
// Function
// - power-ok stays low whenever the core supply is not valid.
// - the cartridge regulator ok input is ignored for 0.5 ms after supply.
// - reset is released only after power-ok has been valid for an interval.
// - power-ok, once dropped, stays low for at least 10 bus clocks.
// - the active-low processor reset is held for at least 1 ms each time.
// - power-ok combines all regulator module goods and the cartridge ok.
`timescale 1ns/1ps
`default_nettype none
`include "ppg_defs.svh"
module ppg_seq #(
    parameter int N_REG = 2,
    parameter int IGNORE_CYC = `PPG_IGNORE_CYC,
    parameter int OK_TIMEOUT_CYC = `PPG_OK_TIMEOUT_CYC,
    parameter int RST_CYC = `PPG_RST_CYC,
    parameter int PG_TO_RST_CYC = `PPG_PG_TO_RST_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // supply status
    input wire logic [N_REG-1:0] regulator_module_good_i,
    input wire logic cartridge_regulator_ok_i,
    input wire logic core_supply_in_range_i,
    // processor pins
    output logic processor_power_ok_o,
    output logic processor_reset_n_o,
    // status
    output logic ok_timeout_o
);
    localparam logic [`PPG_CNT_W-1:0] PG_LOW_MIN =
        `PPG_CNT_W'(`PPG_PG_LOW_MIN_CYC);

    typedef struct packed {
        ppg_pkg::ppg_state_t st;
        logic [`PPG_CNT_W-1:0] cnt;
        logic [`PPG_CNT_W-1:0] low_cnt;
        logic pg;
        logic rst_n;
        logic tmo;
    } ppg_seq_st_t;

    ppg_seq_st_t s_r;
    ppg_seq_st_t s_nxt;
    logic [1:0] rsync_r;
    logic srst_n;
    logic supply_ok;
    logic all_good;

    ppg_sync_if #(.N_REG(N_REG)) sy ();

    // counter limit test shared by the settle, wait-ok and reset-hold states
    function automatic logic reached(input logic [`PPG_CNT_W-1:0] c,
        input int lim);
        reached = (c >= `PPG_CNT_W'(lim - 1));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rsync_r <= 2'h0;
        else
            rsync_r <= {rsync_r[0], 1'h1};
    end
    assign srst_n = rsync_r[1];

    // input synchroniser
    ppg_sync #(.N_REG(N_REG)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(srst_n),
        .regulator_module_good_i(regulator_module_good_i),
        .cartridge_regulator_ok_i(cartridge_regulator_ok_i),
        .core_supply_in_range_i(core_supply_in_range_i),
        .sy(sy)
    );

    ////////////////////////////////////////////////////////////////////////
    // supply valid needs core supply and every module good
    assign supply_ok = sy.core_supply_in_range & (&sy.regulator_module_good);
    assign all_good = supply_ok & sy.cartridge_regulator_ok;

    // sequencer next state
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.cnt = s_r.cnt + `PPG_CNT_W'(1);
        // low-time counter runs while power-ok is low
        if (s_r.pg)
            s_nxt.low_cnt = '0;
        else if (s_r.low_cnt != PG_LOW_MIN)
            s_nxt.low_cnt = s_r.low_cnt + `PPG_CNT_W'(1);
        case (s_r.st)
            ppg_pkg::PPG_OFF:
            begin
                s_nxt.cnt = '0;
                if (supply_ok)
                    s_nxt.st = ppg_pkg::PPG_SETTLE;
            end
            ppg_pkg::PPG_SETTLE:
            begin
                // ok input not trusted yet
                if (reached(s_r.cnt, IGNORE_CYC))
                begin
                    s_nxt.st = ppg_pkg::PPG_WAIT_OK;
                    s_nxt.cnt = '0;
                end
            end
            ppg_pkg::PPG_WAIT_OK:
            begin
                // timeout no shorter than the 13 ms limit
                if (sy.cartridge_regulator_ok)
                begin
                    s_nxt.st = ppg_pkg::PPG_PG_LOW;
                    s_nxt.cnt = '0;
                end
                else if (reached(s_r.cnt, OK_TIMEOUT_CYC))
                begin
                    s_nxt.st = ppg_pkg::PPG_FAULT;
                    s_nxt.tmo = 1'h1;
                end
            end
            ppg_pkg::PPG_PG_LOW:
            begin
                // minimum low width before raising power-ok
                if (s_r.low_cnt == PG_LOW_MIN)
                begin
                    s_nxt.st = ppg_pkg::PPG_RST_HOLD;
                    s_nxt.pg = 1'h1;
                    s_nxt.cnt = '0;
                end
            end
            ppg_pkg::PPG_RST_HOLD:
            begin
                // reset low for pg delay and at least 1 ms
                if (reached(s_r.cnt, PG_TO_RST_CYC) &&
                    reached(s_r.cnt, RST_CYC))
                begin
                    s_nxt.st = ppg_pkg::PPG_RUN;
                    s_nxt.rst_n = 1'h1;
                end
            end
            ppg_pkg::PPG_RUN:
                s_nxt.cnt = '0;
            ppg_pkg::PPG_FAULT:
                s_nxt.cnt = '0;
            default:
                s_nxt.st = ppg_pkg::PPG_OFF;
        endcase
        // a core supply or module good drop restarts everything
        // a cartridge ok drop in the low phase must not let power-ok rise
        if (!supply_ok ||
            ((s_r.pg || s_r.st == ppg_pkg::PPG_PG_LOW) && !all_good))
        begin
            s_nxt.st = ppg_pkg::PPG_OFF;
            s_nxt.pg = 1'h0;
            s_nxt.rst_n = 1'h0;
            s_nxt.cnt = '0;
            s_nxt.tmo = 1'h0;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge srst_n)
    begin
        if (!srst_n)
        begin
            s_r.st <= ppg_pkg::PPG_OFF;
            s_r.cnt <= '0;
            s_r.low_cnt <= '0;
            s_r.pg <= 1'h0;
            s_r.rst_n <= 1'h0;
            s_r.tmo <= 1'h0;
        end
        else
            s_r <= s_nxt;
    end

    assign processor_power_ok_o = s_r.pg;
    assign processor_reset_n_o = s_r.rst_n;
    assign ok_timeout_o = s_r.tmo;

    ////////////////////////////////////////////////////////////////////////
    // checks
    int unsigned rst_low_cnt;
    always_ff @(posedge clk_i or negedge srst_n)
    begin
        if (!srst_n)
            rst_low_cnt <= 0;
        else if (s_r.rst_n)
            rst_low_cnt <= 0;
        else
            rst_low_cnt <= rst_low_cnt + 1;
    end

    // cycles spent in settle, for the ignore-window check
    int unsigned settle_cnt;
    always_ff @(posedge clk_i or negedge srst_n)
    begin
        if (!srst_n)
            settle_cnt <= 0;
        else if (s_r.st == ppg_pkg::PPG_SETTLE)
            settle_cnt <= settle_cnt + 1;
        else
            settle_cnt <= 0;
    end

    sequence s_pg_fall;
        $fell(s_r.pg);
    endsequence

    property p_settle_len;
        @(posedge clk_i) disable iff (!srst_n)
        $past(s_r.st) == ppg_pkg::PPG_SETTLE &&
            s_r.st == ppg_pkg::PPG_WAIT_OK |-> settle_cnt >= IGNORE_CYC;
    endproperty
    a_settle_len: assert property (p_settle_len)
        else $error("settle window left before its length");

    property p_pg_rise_needs_ok;
        @(posedge clk_i) disable iff (!srst_n)
        $rose(s_r.pg) |-> $past(all_good);
    endproperty
    a_pg_rise_needs_ok: assert property (p_pg_rise_needs_ok)
        else $error("power ok rose while an input was low");

    property p_pg_needs_supply;
        @(posedge clk_i) disable iff (!srst_n)
        !supply_ok |=> !s_r.pg;
    endproperty
    a_pg_needs_supply: assert property (p_pg_needs_supply)
        else $error("power ok high without valid core supply");

    property p_pg_low_width;
        @(posedge clk_i) disable iff (!srst_n)
        s_pg_fall |-> !s_r.pg [*8] ##1 !s_r.pg ##1 !s_r.pg;
    endproperty
    a_pg_low_width: assert property (p_pg_low_width)
        else $error("power ok low pulse shorter than ten clocks");

    property p_rst_width;
        @(posedge clk_i) disable iff (!srst_n)
        $rose(s_r.rst_n) |-> $past(rst_low_cnt) >= RST_CYC - 1;
    endproperty
    a_rst_width: assert property (p_rst_width)
        else $error("reset released too early");

    property p_rst_after_pg;
        @(posedge clk_i) disable iff (!srst_n)
        s_r.rst_n |-> s_r.pg;
    endproperty
    a_rst_after_pg: assert property (p_rst_after_pg)
        else $error("reset released without power ok");

    property p_settle_ignores_ok;
        @(posedge clk_i) disable iff (!srst_n)
        $rose(s_r.st == ppg_pkg::PPG_SETTLE) |-> !s_r.pg [*8];
    endproperty
    a_settle_ignores_ok: assert property (p_settle_ignores_ok)
        else $error("power ok rose during settle window");

    property p_combined;
        @(posedge clk_i) disable iff (!srst_n)
        s_r.pg && !all_good |=> !s_r.pg && !s_r.rst_n;
    endproperty
    a_combined: assert property (p_combined)
        else $error("power ok held after an input dropped");

    property p_restart;
        @(posedge clk_i) disable iff (!srst_n)
        !supply_ok |=> s_r.st == ppg_pkg::PPG_OFF;
    endproperty
    a_restart: assert property (p_restart)
        else $error("sequence not restarted on input drop");

    property p_timeout_state;
        @(posedge clk_i) disable iff (!srst_n)
        $rose(s_r.tmo) |-> s_r.st == ppg_pkg::PPG_FAULT && !s_r.pg;
    endproperty
    a_timeout_state: assert property (p_timeout_state)
        else $error("timeout flagged outside fault state");
endmodule
`default_nettype wire

// File: test/ppg_supply_model.sv
// Purpose: regulator modules and cartridge regulator seen by the sequencer
// Assumes: bench drives controls at the falling edge
// Notes: false_high_i mimics the pull-up on the ok line before power
`timescale 1ns/1ps
`default_nettype none
module ppg_supply_model #(
    parameter int N_REG = 2
) (
    // clock
    input wire logic clk_i,
    // controls from the bench
    input wire logic supply_on_i,
    input wire logic false_high_i,
    input wire logic ok_block_i,
    input wire logic [N_REG-1:0] module_drop_i,
    input wire logic [7:0] ok_delay_i,
    // status toward the sequencer
    output logic [N_REG-1:0] regulator_module_good_o,
    output logic cartridge_regulator_ok_o,
    output logic core_supply_in_range_o
);
    logic [7:0] age_r;

    // cycles since the supply came up, saturating
    always_ff @(posedge clk_i)
    begin
        if (!supply_on_i)
            age_r <= 8'h00;
        else if (age_r != 8'hFF)
            age_r <= age_r + 8'h01;
    end

    // modules report good only while the supply is on and they are not dropped
    assign core_supply_in_range_o = supply_on_i;
    assign regulator_module_good_o = supply_on_i ? ~module_drop_i : '0;
    // ok rises a bounded time after supply, or reads high early
    assign cartridge_regulator_ok_o = !ok_block_i && (false_high_i ||
        (supply_on_i && age_r >= ok_delay_i));
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: self-checking bench for the power-ok sequencer
// Assumes: shortened counts 20, 60, 30, 30
// Notes: a monitor judges pulse widths on every rise
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int NR = 2;
    localparam int IGN = 20;
    localparam int TMO = 60;
    localparam int RSTC = 30;
    localparam int PGR = 30;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic supply_on = 1'b0;
    logic false_high = 1'b0;
    logic ok_block = 1'b0;
    logic [NR-1:0] mod_drop = '0;
    logic [7:0] ok_delay = 8'h05;
    logic [NR-1:0] mod_good;
    logic cart_ok, core_ok, pok, prst_n, tmo_flag;
    logic [31:0] seed = 32'h27BE;
    int errors = 0;
    int checks = 0;
    int n, pg_low, rst_low, pg_high, sup_low;

    ////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #2 clk_i = ~clk_i;
    ppg_supply_model #(.N_REG(NR)) u_model (.clk_i(clk_i),
        .supply_on_i(supply_on), .false_high_i(false_high),
        .ok_block_i(ok_block), .module_drop_i(mod_drop),
        .ok_delay_i(ok_delay), .regulator_module_good_o(mod_good),
        .cartridge_regulator_ok_o(cart_ok), .core_supply_in_range_o(core_ok));
    ppg_seq #(.N_REG(NR), .IGNORE_CYC(IGN), .OK_TIMEOUT_CYC(TMO),
        .RST_CYC(RSTC), .PG_TO_RST_CYC(PGR)) u_dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .regulator_module_good_i(mod_good),
        .cartridge_regulator_ok_i(cart_ok), .core_supply_in_range_i(core_ok),
        .processor_power_ok_o(pok), .processor_reset_n_o(prst_n),
        .ok_timeout_o(tmo_flag));

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic int gap();
        return (RSTC > PGR) ? RSTC : PGR;
    endfunction
    function automatic logic pick(input int sel);
        return (sel == 0) ? pok : (sel == 1) ? prst_n : tmo_flag;
    endfunction
    task automatic check_bit(input string what, input logic exp,
        input logic got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0b seen %0b", what, exp, got);
        end
    endtask
    task automatic check_min(input string what, input int lo, input int got);
        checks++;
        if (got < lo)
        begin
            errors++;
            $display("MISMATCH %s expected >=%0d seen %0d", what, lo, got);
        end
    endtask
    task automatic wait_high(input int sel, input int lim, output int cnt);
        cnt = 0;
        // outputs are looked at half a period after the edge that sets them
        while (pick(sel) !== 1'b1 && cnt < lim)
        begin
            @(negedge clk_i);
            cnt++;
        end
        check_bit("wait in time", 1'b1, cnt < lim);
    endtask
    task automatic power_up(input logic [7:0] dly, input logic fh,
        input logic blk);
        ok_delay = dly;
        false_high = fh;
        ok_block = blk;
        supply_on = 1'b1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // monitor: run lengths judged at each rise, sampled mid-period
    always @(negedge clk_i)
    begin
        if (pok === 1'b1 && pg_low > 0)
            check_min("power ok low run", 10, pg_low);
        if (prst_n === 1'b1 && rst_low > 0)
        begin
            check_min("reset low run", RSTC, rst_low);
            check_min("ok before reset", PGR, pg_high);
        end
        if (sup_low > 4)
            check_bit("ok with bad core", 1'b0, pok);
        pg_low = (pok === 1'b1) ? 0 : pg_low + 1;
        rst_low = (prst_n === 1'b1) ? 0 : rst_low + 1;
        pg_high = (pok === 1'b1) ? pg_high + 1 : 0;
        sup_low = core_ok ? 0 : sup_low + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        // random power-ups with early false ok, then drop one source
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            power_up(8'(seed[4:0] + 1), i == 0 || seed[8], 1'b0);
            wait_high(0, 200, n);
            check_min("ok rise delay", IGN, n);
            wait_high(1, 200, n);
            check_min("reset after ok", gap(), n);
            check_bit("no timeout", 1'b0, tmo_flag);
            case (seed[10:9])
                2'd0: supply_on = 1'b0;
                2'd1: mod_drop = 2'b01 << seed[11];
                default: ok_block = 1'b1;
            endcase
            repeat (5) @(negedge clk_i);
            check_bit("ok after drop", 1'b0, pok);
            check_bit("reset after drop", 1'b0, prst_n);
            supply_on = 1'b0;
            mod_drop = '0;
            ok_block = 1'b0;
            repeat (seed[14:12] + 1) @(negedge clk_i);
        end
        // cartridge ok never comes
        power_up(8'h05, 1'b0, 1'b1);
        wait_high(2, 300, n);
        check_min("timeout delay", IGN + TMO, n);
        check_bit("ok in fault", 1'b0, pok);
        supply_on = 1'b0;
        repeat (5) @(negedge clk_i);
        check_bit("timeout cleared", 1'b0, tmo_flag);
        tally_and_finish();
    end

    // watchdog
    initial
    begin
        #80000;
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
